// file: hdl/isp_flash_program_control.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module isp_flash_program_control
  import isp_pkg::*;
#(
  parameter int FLASH_ADDR_W = 16 // flash array address width
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic hw_reboot_strap, // loader reboot strap, caught after reset
  input wire logic timer_expired, // cpu timer time-out pulse
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic flash_req_valid, // flash op request
  output flash_req_t flash_req, // flash op payload
  output logic flash_chip_enable_n, // chip enable to array
  output logic flash_output_enable_n, // output enable to array
  input wire logic flash_done, // flash op complete pulse
  input wire logic [7:0] flash_rdata, // read byte, valid with flash_done
  output logic loader_fetch_select, // fetch from loader area
  output logic cpu_idle, // cpu held in genuine idle
  output logic cpu_isp_hold, // cpu held while flash op runs
  output logic device_reset_req // whole-device reset pulse
);

  // ****************************************
  // registers
  // ****************************************
  logic soft_reset_reboot_q;
  logic loader_exec_status_q;
  logic loader_fetch_select_q;
  logic isp_mode_enable_q;
  logic [7:0] addr_low_q;
  logic [7:0] addr_high_q;
  logic [7:0] data_buf_q;
  logic [7:0] opmode_q;
  logic idle_q;
  logic armed_q;
  logic strap_seen_q;
  logic reset_req_q;
  seq_state_t state_q;

  // ****************************************
  // axi write channel
  // ****************************************
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic wr_lane0;
  logic wr_hit;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx = aw_addr_q[9:2];
  assign wr_lane0 = w_strb_q[0];
  assign wr_hit = (wr_idx == ISP_CONTROL_IDX) || (wr_idx == ISP_ADDRESS_LOW_IDX)
               || (wr_idx == ISP_ADDRESS_HIGH_IDX) || (wr_idx == ISP_DATA_BUFFER_IDX)
               || (wr_idx == ISP_OPERATION_MODE_IDX) || (wr_idx == POWER_CONTROL_IDX)
               || (wr_idx == ISP_STATUS_IDX);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_en;
  logic [7:0] wr_byte;
  assign wr_en = wr_fire && wr_lane0;
  assign wr_byte = w_data_q[7:0];

  // ****************************************
  // control register
  // ****************************************
  // strap caught by a clocked process after release, never at reset itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_seen_q <= 1'b0;
      soft_reset_reboot_q <= 1'b0;
      loader_exec_status_q <= 1'b0;
    end else begin
      if (!strap_seen_q) begin
        strap_seen_q <= 1'b1;
        soft_reset_reboot_q <= hw_reboot_strap;
        loader_exec_status_q <= hw_reboot_strap;
      end else if (reset_req_q) begin
        soft_reset_reboot_q <= 1'b0;
      end else if (wr_en && wr_idx == ISP_CONTROL_IDX && wr_byte[CTL_SOFT_RESET_BIT]) begin
        soft_reset_reboot_q <= 1'b1;
      end
      // executing area follows fetch routing
      if (strap_seen_q) begin
        loader_exec_status_q <= loader_fetch_select_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loader_fetch_select_q <= 1'b0;
      isp_mode_enable_q <= 1'b0;
    end else if (wr_en && wr_idx == ISP_CONTROL_IDX) begin
      loader_fetch_select_q <= wr_byte[CTL_FETCH_SEL_BIT];
      isp_mode_enable_q <= wr_byte[CTL_ISP_EN_BIT];
    end
  end

  // software reset arms when the 0x83 pattern is written, then fires on timer time-out in idle or while a flash op runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
      reset_req_q <= 1'b0;
    end else begin
      reset_req_q <= 1'b0;
      if (wr_en && wr_idx == ISP_CONTROL_IDX) begin
        armed_q <= (wr_byte == SOFT_RESET_CODE);
        // plain write of bit 7 without the pattern resets at once
        if (wr_byte[CTL_SOFT_RESET_BIT] && wr_byte != SOFT_RESET_CODE) begin
          reset_req_q <= 1'b1;
        end
      end else if (armed_q && (idle_q || state_q != ST_IDLE) && timer_expired) begin
        armed_q <= 1'b0;
        reset_req_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // isp address, data, mode
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_low_q <= BYTE_RESET;
      addr_high_q <= BYTE_RESET;
      opmode_q <= OPM_RESET;
      idle_q <= 1'b0;
    end else begin
      if (wr_en && wr_idx == ISP_ADDRESS_LOW_IDX) addr_low_q <= wr_byte;
      if (wr_en && wr_idx == ISP_ADDRESS_HIGH_IDX) addr_high_q <= wr_byte;
      if (wr_en && wr_idx == ISP_OPERATION_MODE_IDX) opmode_q <= wr_byte;
      // idle bit is cleared by hardware when the carried operation ends
      if (state_q == ST_DONE) begin
        idle_q <= 1'b0;
      end else if (wr_en && wr_idx == POWER_CONTROL_IDX) begin
        idle_q <= wr_byte[POWER_CONTROL_REG_IDLE_BIT];
      end
    end
  end

  // flash read result wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_buf_q <= BYTE_RESET;
    end else if (state_q == ST_WAIT && flash_done && flash_req.op == OP_READ) begin
      data_buf_q <= flash_rdata;
    end else if (wr_en && wr_idx == ISP_DATA_BUFFER_IDX) begin
      data_buf_q <= wr_byte;
    end
  end

  // ****************************************
  // flash sequencer
  // ****************************************
  logic [15:0] req_addr;
  always_comb begin
    req_addr = {addr_high_q, addr_low_q};
    if (opmode_q[OPM_BANK_BIT]) begin
      req_addr = {4'h0, req_addr[11:0]}; // loader area is 4 KB
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      flash_req <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (isp_mode_enable_q && idle_q) begin
            flash_req.bank <= opmode_q[OPM_BANK_BIT];
            flash_req.op <= opmode_q[3:0];
            // erase covers the whole bank, address and data unused
            flash_req.addr <= (opmode_q[3:0] == OP_ERASE) ? 16'h0000 : req_addr;
            flash_req.wdata <= (opmode_q[3:0] == OP_PROGRAM) ? data_buf_q : 8'h00;
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: state_q <= ST_WAIT;
        ST_WAIT: if (flash_done) state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // unknown op codes are passed on; the array model treats them as a read and still reports done
  assign flash_req_valid = (state_q == ST_ISSUE);
  assign flash_chip_enable_n = opmode_q[OPM_CE_N_BIT];
  assign flash_output_enable_n = opmode_q[OPM_OE_N_BIT];
  assign cpu_isp_hold = (state_q != ST_IDLE) || (isp_mode_enable_q && idle_q);
  assign cpu_idle = idle_q && !isp_mode_enable_q && state_q == ST_IDLE;
  assign loader_fetch_select = loader_fetch_select_q;
  assign device_reset_req = reset_req_q;

  // ****************************************
  // axi read channel
  // ****************************************
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    case (s_axi_araddr[9:2])
      ISP_CONTROL_IDX: rd_byte = {soft_reset_reboot_q, 1'b0, loader_exec_status_q, 3'b000,
                                  loader_fetch_select_q, isp_mode_enable_q};
      ISP_ADDRESS_LOW_IDX: rd_byte = addr_low_q;
      ISP_ADDRESS_HIGH_IDX: rd_byte = addr_high_q;
      ISP_DATA_BUFFER_IDX: rd_byte = data_buf_q;
      ISP_OPERATION_MODE_IDX: rd_byte = opmode_q;
      POWER_CONTROL_IDX: rd_byte = {6'h00, idle_q, 1'b0};
      ISP_STATUS_IDX: rd_byte = {6'h00, cpu_idle, state_q != ST_IDLE};
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : isp_flash_program_control

// file: hdl/isp_pkg.sv
package isp_pkg;

  // ****************************************
  // register indices
  // ****************************************
  // printed offsets 0x9f, 0xad, 0xaf are not multiples of four: index, byte address = 4 * index
  localparam logic [7:0] ISP_CONTROL_IDX = 8'h9f;
  localparam logic [7:0] ISP_ADDRESS_LOW_IDX = 8'hac;
  localparam logic [7:0] ISP_ADDRESS_HIGH_IDX = 8'had;
  localparam logic [7:0] ISP_DATA_BUFFER_IDX = 8'hae;
  localparam logic [7:0] ISP_OPERATION_MODE_IDX = 8'haf;
  localparam logic [7:0] POWER_CONTROL_IDX = 8'h87;
  localparam logic [7:0] ISP_STATUS_IDX = 8'hb0;
  localparam int ADDR_W = 12;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTL_SOFT_RESET_BIT = 7;
  localparam int CTL_LOADER_EXEC_BIT = 5;
  localparam int CTL_FETCH_SEL_BIT = 1;
  localparam int CTL_ISP_EN_BIT = 0;
  localparam int OPM_BANK_BIT = 7;
  localparam int OPM_OE_N_BIT = 6;
  localparam int OPM_CE_N_BIT = 5;
  localparam int POWER_CONTROL_REG_IDLE_BIT = 1;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_IDLE_BIT = 1;

  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] OPM_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] OP_ERASE = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h1;
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [7:0] SOFT_RESET_CODE = 8'h83;
  localparam int LOADER_BYTES = 4096;
  localparam int APP_BYTES = 65536;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ISSUE = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } seq_state_t;

  typedef struct packed {
    logic bank;      // 1 loader area, 0 application area
    logic [3:0] op;
    logic [15:0] addr;
    logic [7:0] wdata;
  } flash_req_t;

endpackage : isp_pkg

// file: sim/isp_flash_program_control_chk.sv
`timescale 1ns/1ns
// ****************************************
// sequencer port checker
// ****************************************
module isp_flash_program_control_chk
  import isp_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic s_axi_rvalid, // read data valid
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic flash_req_valid, // flash op request
  input wire flash_req_t flash_req, // flash op payload
  input wire logic flash_done, // flash op complete
  input wire logic cpu_idle, // genuine idle
  input wire logic cpu_isp_hold, // held for flash op
  input wire logic device_reset_req // device reset pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  req_pulse_a: assert property (flash_req_valid |=> !flash_req_valid)
    else $error("flash request wider than one cycle");
  req_hold_a: assert property (flash_req_valid |-> cpu_isp_hold && !cpu_idle)
    else $error("flash request without cpu hold");
  hold_start_a: assert property ($rose(cpu_isp_hold) |-> ##[0:2] flash_req_valid)
    else $error("cpu held but no flash request");
  idle_plain_a: assert property (cpu_idle |-> !cpu_isp_hold && !flash_req_valid)
    else $error("genuine idle during flash op");
  payload_hold_a: assert property (cpu_isp_hold && !flash_req_valid |-> $stable(flash_req))
    else $error("flash payload moved during op");
  erase_clean_a: assert property (flash_req_valid && flash_req.op == OP_ERASE
    |-> flash_req.addr == 16'h0000 && flash_req.wdata == 8'h00) else $error("erase payload not zero");
  loader_mask_a: assert property (flash_req_valid && flash_req.bank |-> flash_req.addr[15:12] == 4'h0)
    else $error("loader address beyond bank");
  done_release_a: assert property (flash_done && cpu_isp_hold |-> ##[1:2] !cpu_isp_hold)
    else $error("cpu hold not released after done");
  reset_pulse_a: assert property (device_reset_req |=> !device_reset_req)
    else $error("reset request wider than one cycle");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
endmodule : isp_flash_program_control_chk

bind isp_flash_program_control isp_flash_program_control_chk i_isp_flash_program_control_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .flash_req_valid(flash_req_valid), .flash_req(flash_req), .flash_done(flash_done),
  .cpu_idle(cpu_idle), .cpu_isp_hold(cpu_isp_hold), .device_reset_req(device_reset_req));

// file: sim/flash_array_model.sv
`timescale 1ns/1ns
// ****************************************
// code flash array, both banks
// ****************************************
module flash_array_model
  import isp_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic flash_req_valid, // op request
  input wire flash_req_t flash_req, // op payload
  output logic flash_done, // done pulse
  output logic [7:0] flash_rdata // read byte
);
  logic [7:0] ld_mem [LOADER_BYTES];
  logic [7:0] ap_mem [APP_BYTES];
  initial begin
    flash_done = 1'b0;
    flash_rdata = 8'h00;
  end
  // odd addresses answer slowly to stretch the cpu hold
  always @(posedge aclk) begin
    if (flash_req_valid === 1'b1) begin
      repeat (flash_req.addr[0] ? 12 : 1) @(posedge aclk);
      case (flash_req.op)
        OP_ERASE: begin
          if (flash_req.bank) foreach (ld_mem[i]) ld_mem[i] = 8'hff;
          else foreach (ap_mem[i]) ap_mem[i] = 8'hff;
        end
        OP_PROGRAM: begin
          if (flash_req.bank) ld_mem[flash_req.addr[11:0]] = flash_req.wdata;
          else ap_mem[flash_req.addr] = flash_req.wdata;
        end
        default: flash_rdata <= flash_req.bank ? ld_mem[flash_req.addr[11:0]] : ap_mem[flash_req.addr];
      endcase
      flash_done <= 1'b1;
      @(posedge aclk);
      flash_done <= 1'b0;
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule : flash_array_model

// file: sim/isp_flash_program_control_test.sv
`timescale 1ns/1ns
module isp_flash_program_control_test
  import isp_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, strap = 1'b0, timer = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic awready, wready, bvalid, arready, rvalid, freq_v, ce_n, oe_n, fdone, fsel, cpu_idle, hold, dev_rst;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] frdata;
  flash_req_t freq;
  int num_errors = 0, n_checks = 0, cyc = 0, nrst = 0;
  always #20 aclk = ~aclk;

  isp_flash_program_control i_isp_flash_program_control (.aclk(aclk), .aresetn(aresetn),
    .hw_reboot_strap(strap), .timer_expired(timer), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_req_valid(freq_v),
    .flash_req(freq), .flash_chip_enable_n(ce_n), .flash_output_enable_n(oe_n), .flash_done(fdone),
    .flash_rdata(frdata), .loader_fetch_select(fsel), .cpu_idle(cpu_idle), .cpu_isp_hold(hold),
    .device_reset_req(dev_rst));
  flash_array_model i_flash_array_model (.aclk(aclk), .flash_req_valid(freq_v), .flash_req(freq),
    .flash_done(fdone), .flash_rdata(frdata));

  // ****************************************
  // compare, bus tasks
  // ****************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // ready and valid are looked at mid-cycle, where they hold until the next edge
  task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic a, w, b;
    awaddr <= {2'b00, ix, 2'b00};
    wdata <= {24'h000000, d};
    {awvalid, wvalid, bready} <= 3'b111;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      a = (awready === 1'b1);
      w = (wready === 1'b1);
      b = (bvalid === 1'b1);
      if (b) cmp(32'(bresp), 32'(er));
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    // one idle edge, so a following call never re-raises bready in the step that lowered it
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] ix, input logic [7:0] e, input logic [1:0] er = RESP_OKAY,
                    input logic [31:0] m = 32'hffffffff);
    logic a, r;
    araddr <= {2'b00, ix, 2'b00};
    {arvalid, rready} <= 2'b11;
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      a = (arready === 1'b1);
      r = (rvalid === 1'b1);
      if (r) cmp(rdata & m, {24'h000000, e});
      if (r) cmp(32'(rresp), 32'(er));
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end
    // same spacing as writes: rready is lowered and raised at different edges
    @(posedge aclk);
  endtask : rd
  task automatic idle_wait;
    for (int i = 0; i < 40 && hold !== 1'b0; i++) @(negedge aclk);
    cmp(32'(hold), 32'h0);
    @(posedge aclk);
  endtask : idle_wait
  task automatic op(input logic b, input logic [3:0] c, input logic [15:0] ad, input logic [7:0] d);
    wr(ISP_ADDRESS_LOW_IDX, ad[7:0]);
    wr(ISP_ADDRESS_HIGH_IDX, ad[15:8]);
    wr(ISP_DATA_BUFFER_IDX, d);
    wr(ISP_OPERATION_MODE_IDX, {b, c != OP_READ, 2'b00, c});
    wr(ISP_CONTROL_IDX, 8'h01);
    wr(POWER_CONTROL_IDX, 8'h02);
    @(negedge aclk);
    cmp(32'({hold, cpu_idle, ce_n, oe_n}), 32'({3'b100, c != OP_READ}));
    idle_wait();
  endtask : op
  task automatic tick;
    timer <= 1'b1;
    @(posedge aclk);
    timer <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : tick
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (dev_rst === 1'b1) nrst <= nrst + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      summarize();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ISP_CONTROL_IDX, CTL_RESET);
    rd(ISP_OPERATION_MODE_IDX, OPM_RESET);
    wr(ISP_CONTROL_IDX, 8'h02);
    cmp(32'(fsel), 32'h1);
    rd(ISP_CONTROL_IDX, 8'h22);
    wr(ISP_CONTROL_IDX, 8'h20);
    rd(ISP_CONTROL_IDX, 8'h00);
    wr(8'h10, 8'h55, RESP_SLVERR);
    rd(8'h10, 8'h00, RESP_SLVERR);
    op(1'b0, OP_ERASE, 16'h0000, 8'h00);
    op(1'b1, OP_ERASE, 16'h0000, 8'h00);
    op(1'b0, OP_PROGRAM, 16'h1235, 8'h5a);
    op(1'b1, OP_PROGRAM, 16'h0123, 8'ha5);
    op(1'b0, OP_READ, 16'h1235, 8'h00);
    rd(ISP_DATA_BUFFER_IDX, 8'h5a);
    op(1'b0, OP_READ, 16'h1236, 8'h00);
    rd(ISP_DATA_BUFFER_IDX, 8'hff);
    op(1'b1, OP_READ, 16'h1123, 8'h00);
    rd(ISP_DATA_BUFFER_IDX, 8'ha5);
    rd(ISP_ADDRESS_HIGH_IDX, 8'h11);
    rd(POWER_CONTROL_IDX, 8'h00);
    wr(ISP_CONTROL_IDX, 8'h00);
    wr(POWER_CONTROL_IDX, 8'h02);
    rd(ISP_STATUS_IDX, 8'h02);
    cmp(32'({cpu_idle, hold}), 32'h2);
    wr(POWER_CONTROL_IDX, 8'h00);
    wr(ISP_CONTROL_IDX, 8'h80);
    rd(ISP_CONTROL_IDX, 8'h00);
    cmp(32'(nrst), 32'h1);
    wr(ISP_CONTROL_IDX, SOFT_RESET_CODE);
    tick();
    cmp(32'(nrst), 32'h1);
    wr(POWER_CONTROL_IDX, 8'h02);
    tick();
    cmp(32'(nrst), 32'h2);
    idle_wait();
    aresetn <= 1'b0;
    strap <= 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ISP_CONTROL_IDX, 8'h80, RESP_OKAY, 32'h80);
    summarize();
  end
endmodule : isp_flash_program_control_test
